/* src/term_map_pkg.sv */
// package: register map, function codes and carrier types of the terminal mapper
package term_map_pkg;
  localparam logic [7:0] ADDR_IN_SEL = 8'h00;
  localparam logic [7:0] ADDR_OUT_SEL = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_BOK_MS = 8'h0c;
  localparam logic [7:0] ADDR_TOK_MS = 8'h10;
  localparam logic [7:0] ADDR_START_THR = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int TERMS = 5;
  localparam logic [19:0] IN_SEL_RST = 20'h87321;
  localparam logic [24:0] OUT_SEL_RST = {5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
  localparam logic [4:0] IN_CODE_MAX = 5'h0f;
  localparam logic [4:0] OUT_CODE_MAX = 5'h12;
  localparam logic [13:0] OK_MS_RST = 14'h270f;
  localparam logic [15:0] START_THR_RST = 16'h0100;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int CTRL_LCS_LSB = 0;
  localparam int CTRL_JSS_BIT = 2;
  localparam int CTRL_REWRITE_BIT = 3;
  localparam int IF_LIMIT1 = 1;
  localparam int IF_START = 2;
  localparam int IF_RESET = 3;
  localparam int IF_LIMIT2 = 4;
  localparam int IF_FORCE = 5;
  localparam int IF_CLICK = 6;
  localparam int IF_JOBA = 7;
  localparam int IF_JOB1 = 10;
  localparam int IF_STOP = 15;
  localparam int OF_BATCH_OK = 1;
  localparam int OF_BATCH_FAIL = 2;
  localparam int OF_TORQUE_OK = 3;
  localparam int OF_TORQUE_FAIL = 4;
  localparam int OF_START_TQ = 5;
  localparam int OF_LOW = 6;
  localparam int OF_HIGH = 7;
  localparam int OF_ACTIVE = 8;
  localparam int OF_ALIVE = 9;
  localparam int OF_CAUTION = 10;
  localparam int OF_JOB_ECHO = 11;
  localparam int OF_JOB_GOOD = 14;
  localparam int OF_LAST = 18;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // events and levels coming from the controller core, same clock
  typedef struct packed {
    logic batch_good;
    logic batch_fail;
    logic torque_good;
    logic torque_fail;
    logic torque_low;
    logic torque_high;
    logic cycle_start;
    logic cycle_active;
    logic maint_limit;
    logic error_pending;
    logic [15:0] torque_value;
  } core_evt_t;

  // commands handed to the controller core
  typedef struct packed {
    logic judge_trigger;
    logic process_start;
    logic ext_start;
    logic count_reset;
    logic error_clear;
    logic judge_trigger2;
    logic force_complete;
    logic countdown;
    logic stop_tool;
    logic [3:0] job_number;
  } core_cmd_t;

  // whole state of the mapper
  typedef struct packed {
    logic [4:0][3:0] in_sel;
    logic [4:0][4:0] out_sel;
    logic [3:0] ctrl;
    logic [1:0][13:0] ok_ms;
    logic [15:0] start_thr;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic [2:0] job;
    logic [1:0] ok_on;
    logic [1:0][13:0] ok_cnt;
    logic bfail;
    logic tfail;
    logic tlow;
    logic thigh;
    logic st_reached;
    logic [15:0] pre;
    logic [4:0] term_out;
    core_cmd_t cmd;
    logic [31:0] prdata;
  } state_t;
endpackage : term_map_pkg

/* src/terminal_signal_mapper.sv */
// terminal signal mapper: five input and five output terminals, APB configured
// Notes on behaviour
// RULE1 - five input terminals, reset codes 1,2,3,7,8
// RULE2 - limit one judges, or starts process
// RULE3 - function two gives external start
// RULE4 - reset clears count, or error if pending
// RULE5 - limit two judges when line select 1
// RULE6 - force batch complete, batch good asserted
// RULE7 - click wrench counts down one each
// RULE8 - scheme 0: three lines select job
// RULE9 - scheme 1: five lines select job
// RULE10 - external stop ends tool drive
// RULE11 - duplicate code configurations are refused
// RULE12 - five output terminals, reset codes 1..5
// RULE13 - batch good lasts batch pulse time
// RULE14 - fail outputs latch until reset
// RULE15 - torque good lasts torque pulse time
// RULE16 - start torque reached on threshold
// RULE17 - low and high torque rejections
// RULE18 - fastening active follows cycle
// RULE19 - alive drops while settings rewritten
// RULE20 - caution at maintenance limit
// RULE21 - job number echoed on three lines
// RULE22 - per job batch good, jobs 1..5
// RULE23 - zero timer holds until next cycle
// RULE24 - outputs only selected; unassigned inputs inactive
module terminal_signal_mapper
  import term_map_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] term_in,
  output logic [4:0] term_out,
  input wire core_evt_t evt,
  output core_cmd_t cmd
);

  state_t s, n;
  logic [15:0] fa;
  logic [15:0] fa_old;
  logic [15:0] rise;
  logic [OF_LAST:0] of;
  logic [4:0][4:0] in_codes;
  logic wr_bad;
  logic mapped;
  logic acc;
  logic tick;
  logic [1:0] ok_set;
  logic nok_clear;
  logic [4:0] alive_sel;

  // a field is bad when it is out of range or repeats another nonzero code
  function automatic logic codes_bad(input logic [4:0][4:0] c, input logic [4:0] lim);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < TERMS; i++) begin
      if (c[i] > lim) bad = 1'b1;
      for (int j = i + 1; j < TERMS; j++) begin
        if (c[i] != 5'h00 && c[i] == c[j]) bad = 1'b1;
      end
    end
    return bad;
  endfunction : codes_bad

  // decode input functions from synced pins; unassigned codes stay low
  always_comb begin
    fa = 16'h0000;
    fa_old = 16'h0000;
    for (int t = 0; t < TERMS; t++) begin
      fa[s.in_sel[t]] = fa[s.in_sel[t]] | s.sync2[t]; // see RULE24
      fa_old[s.in_sel[t]] = fa_old[s.in_sel[t]] | s.prev[t];
    end
    fa[0] = 1'b0; // code 0 means no function
    fa_old[0] = 1'b0;
    rise = fa & ~fa_old;
  end

  // apb decode; only one write field check is needed per target register
  always_comb begin
    for (int t = 0; t < TERMS; t++) begin
      in_codes[t] = {1'b0, pwdata[4 * t +: 4]};
    end
    acc = psel && penable && ce;
    mapped = 1'b1;
    wr_bad = 1'b0;
    if (paddr == ADDR_IN_SEL) begin
      wr_bad = codes_bad(in_codes, IN_CODE_MAX); // see RULE11
    end else if (paddr == ADDR_OUT_SEL) begin
      wr_bad = codes_bad(pwdata[24:0], OUT_CODE_MAX); // see RULE11
    end else if (paddr == ADDR_CTRL || paddr == ADDR_BOK_MS || paddr == ADDR_TOK_MS) begin
      wr_bad = 1'b0;
    end else if (paddr == ADDR_START_THR || paddr == ADDR_STATUS) begin
      wr_bad = 1'b0;
    end else begin
      mapped = 1'b0;
    end
  end

  // ready follows the clock enable so a frozen block holds the bus
  assign pready = ce;
  assign pslverr = acc && (!mapped || (pwrite && wr_bad));
  assign prdata = s.prdata;
  assign term_out = s.term_out;
  assign cmd = s.cmd;
  assign tick = (s.pre == 16'(MS_CYC - 1));
  assign ok_set[0] = evt.batch_good || rise[IF_FORCE]; // see RULE6
  assign ok_set[1] = evt.torque_good;
  assign nok_clear = rise[IF_RESET];

  // output function vector, indexed by output code
  always_comb begin
    of = '0;
    alive_sel = 5'h00;
    of[OF_BATCH_OK] = s.ok_on[0]; // see RULE13
    of[OF_BATCH_FAIL] = s.bfail; // see RULE14
    of[OF_TORQUE_OK] = s.ok_on[1]; // see RULE15
    of[OF_TORQUE_FAIL] = s.tfail; // see RULE14
    of[OF_START_TQ] = s.st_reached; // see RULE16
    of[OF_LOW] = s.tlow; // see RULE17
    of[OF_HIGH] = s.thigh; // see RULE17
    of[OF_ACTIVE] = evt.cycle_active; // see RULE18
    of[OF_ALIVE] = !s.ctrl[CTRL_REWRITE_BIT]; // see RULE19
    of[OF_CAUTION] = evt.maint_limit; // see RULE20
    of[OF_JOB_ECHO +: 3] = s.job; // see RULE21
    for (int k = 0; k < 5; k++) begin
      of[OF_JOB_GOOD + k] = s.ok_on[0] && (s.job == 3'(k)); // see RULE22
      alive_sel[k] = (s.out_sel[k] == 5'(OF_ALIVE));
    end
  end

  // next state; nothing moves while ce is low
  always_comb begin
    n = s;
    if (ce) begin
      // two-flop pin synchroniser, then edge history
      n.sync1 = term_in;
      n.sync2 = s.sync1;
      n.prev = s.sync2;
      n.pre = tick ? 16'h0000 : s.pre + 16'h0001;

      // commands to the core, registered
      n.cmd.judge_trigger = rise[IF_LIMIT1] && s.ctrl[1:0] == 2'd0; // see RULE2
      n.cmd.process_start = rise[IF_LIMIT1]
        && (s.ctrl[1:0] == 2'd1 || s.ctrl[1:0] == 2'd2); // see RULE2
      n.cmd.ext_start = rise[IF_START]; // see RULE3
      n.cmd.count_reset = rise[IF_RESET] && !evt.error_pending; // see RULE4
      n.cmd.error_clear = rise[IF_RESET] && evt.error_pending; // see RULE4
      n.cmd.judge_trigger2 = rise[IF_LIMIT2] && s.ctrl[1:0] == 2'd1; // see RULE5
      n.cmd.force_complete = rise[IF_FORCE]; // see RULE6
      n.cmd.countdown = rise[IF_CLICK]; // see RULE7
      n.cmd.stop_tool = fa[IF_STOP]; // see RULE10

      // job selection; scheme 1 keeps the last job when no line is high
      if (!s.ctrl[CTRL_JSS_BIT]) begin
        n.job = fa[IF_JOBA +: 3]; // see RULE8
      end else begin
        for (int k = 4; k >= 0; k--) begin
          if (fa[IF_JOB1 + k]) n.job = 3'(k); // see RULE9
        end
      end
      n.cmd.job_number = {1'b0, s.job} + 4'h1;

      // fail latches: a set in the clearing cycle wins
      if (nok_clear) n.bfail = 1'b0;
      if (evt.batch_fail) n.bfail = 1'b1; // see RULE14
      if (nok_clear) n.tfail = 1'b0;
      if (evt.torque_fail) n.tfail = 1'b1; // see RULE14
      if (evt.cycle_start) begin
        n.tlow = 1'b0;
        n.thigh = 1'b0;
      end
      if (evt.torque_low) n.tlow = 1'b1; // see RULE17
      if (evt.torque_high) n.thigh = 1'b1; // see RULE17
      n.st_reached = evt.torque_value >= s.start_thr; // see RULE16

      // ok pulse timers in whole ms; granularity is one ms tick
      for (int k = 0; k < 2; k++) begin
        if (ok_set[k]) begin
          n.ok_on[k] = 1'b1;
          n.ok_cnt[k] = s.ok_ms[k];
        end else if (s.ok_on[k]) begin
          if (s.ok_cnt[k] == 14'h0000) begin
            if (evt.cycle_start) n.ok_on[k] = 1'b0; // see RULE23
          end else if (tick) begin
            if (s.ok_cnt[k] == 14'h0001) n.ok_on[k] = 1'b0; // see RULE13 RULE15
            n.ok_cnt[k] = s.ok_cnt[k] - 14'h0001;
          end
        end
      end

      // each terminal shows only its selected function
      for (int t = 0; t < TERMS; t++) begin
        n.term_out[t] = (s.out_sel[t] <= OUT_CODE_MAX) ? of[s.out_sel[t]] : 1'b0; // see RULE24
      end

      // apb read data captured in the setup cycle
      if (psel && !penable) begin
        n.prdata = 32'h0000_0000;
        if (paddr == ADDR_IN_SEL) begin
          n.prdata[19:0] = s.in_sel;
        end else if (paddr == ADDR_OUT_SEL) begin
          n.prdata[24:0] = s.out_sel;
        end else if (paddr == ADDR_CTRL) begin
          n.prdata[3:0] = s.ctrl;
        end else if (paddr == ADDR_BOK_MS) begin
          n.prdata[13:0] = s.ok_ms[0];
        end else if (paddr == ADDR_TOK_MS) begin
          n.prdata[13:0] = s.ok_ms[1];
        end else if (paddr == ADDR_START_THR) begin
          n.prdata[15:0] = s.start_thr;
        end else if (paddr == ADDR_STATUS) begin
          n.prdata[15:0] = {s.tfail, s.bfail, s.cmd.job_number, s.term_out, s.sync2};
        end
      end

      // apb writes; refused writes leave the register untouched
      if (acc && pwrite && mapped && !wr_bad) begin
        if (paddr == ADDR_IN_SEL) begin
          n.in_sel = pwdata[19:0]; // see RULE1
        end else if (paddr == ADDR_OUT_SEL) begin
          n.out_sel = pwdata[24:0]; // see RULE12
        end else if (paddr == ADDR_CTRL) begin
          n.ctrl = pwdata[3:0];
        end else if (paddr == ADDR_BOK_MS) begin
          n.ok_ms[0] = pwdata[13:0];
        end else if (paddr == ADDR_TOK_MS) begin
          n.ok_ms[1] = pwdata[13:0];
        end else if (paddr == ADDR_START_THR) begin
          n.start_thr = pwdata[15:0];
        end
      end
    end
  end

  // state register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.in_sel <= IN_SEL_RST; // see RULE1
      s.out_sel <= OUT_SEL_RST; // see RULE12
      s.ctrl <= CTRL_RST;
      s.ok_ms <= {OK_MS_RST, OK_MS_RST};
      s.start_thr <= START_THR_RST;
    end else begin
      s <= n;
    end
  end

  // checks on the mapper's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_refuse;
    acc && pwrite && paddr == ADDR_IN_SEL && wr_bad |-> pslverr ##1 $stable(s.in_sel);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad input map accepted"); // see RULE11

  property p_refuse_out;
    acc && pwrite && paddr == ADDR_OUT_SEL && wr_bad |=> $stable(s.out_sel);
  endproperty
  a_refuse_out: assert property (p_refuse_out) else $error("bad output map taken"); // see RULE11

  property p_fail_hold;
    ce && s.bfail && !nok_clear |=> s.bfail;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("batch fail dropped early"); // see RULE14

  property p_stop;
    ce && fa[IF_STOP] |=> cmd.stop_tool;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not passed on"); // see RULE10

  property p_force;
    ce && rise[IF_FORCE] |=> s.ok_on[0] ##0 cmd.force_complete;
  endproperty
  a_force: assert property (p_force) else $error("forced completion lost"); // see RULE6

  property p_zero_hold;
    ce && s.ok_on[1] && s.ok_cnt[1] == 14'h0000 && !evt.cycle_start |=> s.ok_on[1];
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("held torque ok dropped"); // see RULE23

  // an accepted map write must land whole at its access edge
  property p_in_sel_write;
    acc && pwrite && paddr == ADDR_IN_SEL && !wr_bad
      |-> !pslverr ##1 s.in_sel == 20'($past(pwdata));
  endproperty
  a_in_sel_write: assert property (p_in_sel_write) else $error("input map write lost"); // see RULE1

  property p_alive;
    ce && s.ctrl[CTRL_REWRITE_BIT] |=> (term_out & $past(alive_sel)) == 5'h00;
  endproperty
  a_alive: assert property (p_alive) else $error("alive high while rewriting"); // see RULE19

  property p_judge;
    ce && rise[IF_LIMIT1] && s.ctrl[1:0] == 2'd0 |=> cmd.judge_trigger && !cmd.process_start;
  endproperty
  a_judge: assert property (p_judge) else $error("limit one misrouted"); // see RULE2

  property p_err_clear;
    ce && rise[IF_RESET] && evt.error_pending |=> cmd.error_clear && !cmd.count_reset;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("reset cleared count on error"); // see RULE4

  property p_echo;
    ce ##1 ce |-> cmd.job_number == {1'b0, $past(s.job)} + 4'h1;
  endproperty
  a_echo: assert property (p_echo) else $error("job number wrong"); // see RULE21

  property p_proc_start;
    ce && rise[IF_LIMIT1] && (s.ctrl[1:0] == 2'd1 || s.ctrl[1:0] == 2'd2)
      |=> cmd.process_start && !cmd.judge_trigger;
  endproperty
  a_proc_start: assert property (p_proc_start) else $error("limit one start lost"); // see RULE2

  property p_judge2;
    ce && rise[IF_LIMIT2] && s.ctrl[1:0] == 2'd1 |=> cmd.judge_trigger2;
  endproperty
  a_judge2: assert property (p_judge2) else $error("limit two judgment lost"); // see RULE5

  property p_ext_start;
    ce && rise[IF_START] |=> cmd.ext_start;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external start lost"); // see RULE3

  property p_click;
    ce && rise[IF_CLICK] |=> cmd.countdown;
  endproperty
  a_click: assert property (p_click) else $error("click countdown lost"); // see RULE7

  property p_fail_set;
    ce && evt.batch_fail |=> s.bfail;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("batch fail not latched"); // see RULE14

  property p_job_line;
    ce && s.ctrl[CTRL_JSS_BIT] && fa[IF_JOB1] |=> s.job == 3'h0;
  endproperty
  a_job_line: assert property (p_job_line) else $error("job line one ignored"); // see RULE9

endmodule : terminal_signal_mapper

/* verif/plc_model.sv */
// line plc model: drives the terminal pins with a selectable scan lag
module plc_model (
  input wire logic pclk,
  input wire logic [4:0] want,
  input wire logic [1:0] lag,
  output logic [4:0] term_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0][4:0] pipe = '0;
  // a slow plc scan moves its pins up to three cycles after it decides
  always @(posedge pclk) pipe <= {pipe[1:0], want};
  assign term_in = (lag == 2'd0) ? want : pipe[lag - 2'd1];
endmodule : plc_model

/* verif/terminal_signal_mapper_bench.sv */
// bench: register, refusal and terminal function checks of the mapper
module terminal_signal_mapper_bench;
  import term_map_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MSC = 4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, clr = 1'b1, ce = 1'b1;
  logic [4:0] want = 5'h00, term_in, term_out;
  logic [1:0] lag = 2'd0;
  core_evt_t evt = '0;
  core_cmd_t cmd, seen;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  integer seed = 32'h2c8b;
  int fail_count = 0, num_checks = 0, n;
  logic [7:0] ra [6] = '{ADDR_IN_SEL, ADDR_OUT_SEL, ADDR_CTRL, ADDR_BOK_MS, ADDR_TOK_MS,
    ADDR_START_THR};
  logic [31:0] rv [6] = '{{12'h0, IN_SEL_RST}, {7'h0, OUT_SEL_RST}, {28'h0, CTRL_RST},
    {18'h0, OK_MS_RST}, {18'h0, OK_MS_RST}, {16'h0, START_THR_RST}};

  terminal_signal_mapper #(.MS_CYC(MSC)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in),
    .term_out(term_out), .evt(evt), .cmd(cmd));
  plc_model i_plc (.pclk(pclk), .want(want), .lag(lag), .term_in(term_in));

  always #50 pclk = ~pclk;

  // command pulses last one cycle, so keep a sticky record of them
  always @(posedge pclk) seen <= clr ? '0 : (seen | cmd);

  // bus monitor: each completed transfer takes the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("bus", {e[32], e[31:0] & {32{e[33]}}}, {pslverr, prdata & {32{e[33]}}});
    end
  end

  task automatic chk(input string w, input logic [32:0] x, input logic [32:0] g);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, x, g);
    end
  endtask : chk

  // one apb transfer; starts on a fresh edge so a release is never overwritten
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic err, input logic [31:0] x);
    int k;
    exp_q.push_back({~w, err, x});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait on one terminal, sampled at the falling edge where it is settled
  task automatic wait_out(input int i, input logic v, input int lim, input string w);
    n = 0;
    @(negedge pclk);
    while (term_out[i] !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
    chk(w, {32'h0, v}, {32'h0, term_out[i]});
  endtask : wait_out

  task automatic pulse_ok(input int k);
    @(posedge pclk);
    if (k == 1) evt.torque_good <= 1'b1;
    else evt.batch_good <= 1'b1;
    @(posedge pclk);
    evt.torque_good <= 1'b0;
    evt.batch_good <= 1'b0;
  endtask : pulse_ok

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // watchdog at about ten times the expected run length
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    for (int k = 0; k < 6; k++) apb(1'b0, ra[k], 32'h0, 1'b0, rv[k]);
    apb(1'b1, ADDR_IN_SEL, 32'h87311, 1'b1, 32'h0);
    apb(1'b1, ADDR_OUT_SEL, {7'h0, OUT_SEL_RST[24:5], 5'h13}, 1'b1, 32'h0);
    apb(1'b1, ADDR_OUT_SEL, {7'h0, OUT_SEL_RST[24:5], 5'h02}, 1'b1, 32'h0);
    apb(1'b0, ADDR_OUT_SEL, 32'h0, 1'b0, {7'h0, OUT_SEL_RST});
    apb(1'b0, 8'h1c, 32'h0, 1'b1, 32'h0);
    $display("test registers done");
    // fail latches hold until the reset function, which also clears the count
    @(posedge pclk);
    evt.batch_fail <= 1'b1;
    evt.torque_fail <= 1'b1;
    @(posedge pclk);
    evt.batch_fail <= 1'b0;
    evt.torque_fail <= 1'b0;
    repeat (30) @(negedge pclk);
    chk("fails held", 33'h3, {31'h0, term_out[3], term_out[1]});
    @(posedge pclk);
    want <= 5'h05;
    wait_out(1, 1'b0, 10, "fail cleared");
    repeat (2) @(negedge pclk);
    chk("reset cmd", 33'h5, {30'h0, seen.count_reset, seen.error_clear, seen.judge_trigger});
    @(posedge pclk);
    want <= 5'h00;
    clr <= 1'b1;
    evt.error_pending <= 1'b1;
    repeat (6) @(posedge pclk);
    want <= 5'h04;
    clr <= 1'b0;
    repeat (8) @(negedge pclk);
    chk("error cmd", 33'h2, {30'h0, seen.count_reset, seen.error_clear, seen.judge_trigger});
    $display("test latches done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, k ? ADDR_TOK_MS : ADDR_BOK_MS, 32'h2, 1'b0, 32'h0);
      pulse_ok(k);
      wait_out(2 * k, 1'b1, 3, "ok set");
      wait_out(2 * k, 1'b0, 12, "ok end");
      chk("ok length", 33'h1, {32'h0, n >= MSC - 1 && n <= 2 * MSC + 1});
      apb(1'b1, k ? ADDR_TOK_MS : ADDR_BOK_MS, 32'h0, 1'b0, 32'h0);
      pulse_ok(k);
      repeat (40) @(negedge pclk);
      chk("ok held", 33'h1, {32'h0, term_out[2 * k]});
      @(posedge pclk);
      evt.cycle_start <= 1'b1;
      @(posedge pclk);
      evt.cycle_start <= 1'b0;
      wait_out(2 * k, 1'b0, 4, "ok next cycle");
    end
    $display("test ok timers done");
    @(posedge pclk);
    evt.torque_value <= START_THR_RST - 16'h1;
    repeat (5) @(negedge pclk);
    chk("below start", 33'h0, {32'h0, term_out[4]});
    @(posedge pclk);
    evt.torque_value <= START_THR_RST;
    wait_out(4, 1'b1, 3, "start torque");
    apb(1'b1, ADDR_OUT_SEL, {7'h0, 5'h09, 5'h04, 5'h0d, 5'h0c, 5'h0b}, 1'b0, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h8, 1'b0, 32'h0);
    wait_out(4, 1'b0, 3, "alive off");
    apb(1'b1, ADDR_CTRL, 32'h0, 1'b0, 32'h0);
    wait_out(4, 1'b1, 3, "alive on");
    // random job lines with a random plc lag
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      @(posedge pclk);
      lag <= r[3:2];
      want <= {r[1:0], 3'b000};
      repeat (9) @(negedge pclk);
      chk("job", {29'h0, {2'b00, r[1:0]} + 4'd1}, {29'h0, cmd.job_number});
      chk("echo", {31'h0, r[1:0]}, {30'h0, term_out[2:0]});
    end
    $display("test jobs done");
    apb(1'b1, ADDR_IN_SEL, 32'h8732f, 1'b0, 32'h0);
    @(posedge pclk);
    clr <= 1'b1;
    lag <= 2'd0;
    @(posedge pclk);
    clr <= 1'b0;
    want <= 5'h01;
    repeat (6) @(negedge pclk);
    chk("stop", 33'h1, {32'h0, cmd.stop_tool});
    chk("unassigned", 33'h0, {32'h0, seen.judge_trigger});
    $display("test stop done");
    // five command functions at once, with line control select 1
    apb(1'b1, ADDR_IN_SEL, 32'h65421, 1'b0, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1, 1'b0, 32'h0);
    apb(1'b1, ADDR_OUT_SEL, {7'h0, 5'h0a, 5'h08, 5'h07, 5'h06, 5'h0e}, 1'b0, 32'h0);
    @(posedge pclk);
    clr <= 1'b1;
    want <= 5'h00;
    repeat (4) @(posedge pclk);
    clr <= 1'b0;
    want <= 5'h1f;
    evt.torque_low <= 1'b1;
    evt.torque_high <= 1'b1;
    evt.cycle_active <= 1'b1;
    evt.maint_limit <= 1'b1;
    @(posedge pclk);
    evt.torque_low <= 1'b0;
    evt.torque_high <= 1'b0;
    repeat (6) @(negedge pclk);
    r = {26'h0, seen.process_start, seen.ext_start, seen.judge_trigger2, seen.force_complete,
      seen.countdown, seen.judge_trigger};
    chk("commands", 33'h3e, {1'b0, r});
    chk("outputs", 33'h1f, {28'h0, term_out});
    // a frozen block must miss the cycle start that would drop the held batch good
    @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    evt.cycle_start <= 1'b1;
    @(posedge pclk);
    evt.cycle_start <= 1'b0;
    @(posedge pclk);
    ce <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("frozen", 33'h1f, {28'h0, term_out});
    $display("test functions done");
    // scheme 1: the lowest high job line picks the job
    apb(1'b1, ADDR_CTRL, 32'h4, 1'b0, 32'h0);
    apb(1'b1, ADDR_IN_SEL, 32'hedcba, 1'b0, 32'h0);
    for (int k = 0; k < 5; k++) begin
      r = $random(seed);
      @(posedge pclk);
      want <= (r[4:0] & (5'h1e << k)) | (5'h01 << k);
      repeat (6) @(negedge pclk);
      chk("job line", {29'h0, 4'(k + 1)}, {29'h0, cmd.job_number});
      chk("job good", {32'h0, k == 0}, {32'h0, term_out[0]});
    end
    $display("test job lines done");
    end_sim();
  end
endmodule : terminal_signal_mapper_bench
